// >>> rtl/node_id_rom_map_error_addr_regs.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// (RL1) Upper identifier quadlet holds maker code and high part serial.
// (RL2) System reset clears the upper identifier to zero, an invalid value.
// (RL3) EEPROM fills the identifier once, then further changes are blocked.
// (RL4) Without EEPROM firmware writes it once; later writes are ignored.
// (RL5) Upper identifier resets on PCIe reset, global reset pin, or power-on.
// (RL6) Low four identifier bits reset only by global pin or power-on; code also resets them on system reset (nrst).
// (RL7) Lower identifier quadlet behaves like the upper one.
// (RL8) ROM quadlet read address equals base plus low ten offset bits.
// (RL9) ROM base writable in bits 31..10, reset zero, bits 9..0 read zero.
// (RL10) Failed posted write stores low 32 destination offset bits.
// (RL11) Failed posted write stores bus and node number in high capture.
// (RL12) Failed posted write stores upper 16 offset bits in high capture.
// (RL13) Capture registers are read-only, hardware-updated, undefined until first failure.
module node_id_rom_map_error_addr_regs (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pcieRstN,
	input wire logic global_reset_pin_n,
	input wire logic porN,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic eepromPresent,
	input wire logic eepromValid,
	input wire logic eepromUpper,
	input wire logic [31:0] eepromData,
	input wire logic romReadReq,
	input wire logic [47:0] romReadOffset,
	output logic romHostValid,
	output logic [31:0] romHostAddr,
	input wire logic postFail,
	input wire logic [47:0] postFailOffset,
	input wire logic [15:0] postFailSource,
	output logic irq
);
	logic rstN;
	logic busRstIn;
	logic coldRstIn;
	logic busRstN;
	logic coldRstN;
	logic [31:0] romBase_r;
	logic [31:0] romBase_nxt;
	logic [31:0] failLow_r;
	logic [31:0] failLow_nxt;
	logic [31:0] failHigh_r;
	logic [31:0] failHigh_nxt;
	logic [node_id_pkg::IRQ_BITS-1:0] irqStat_r;
	logic [node_id_pkg::IRQ_BITS-1:0] irqStat_nxt;
	logic [node_id_pkg::IRQ_BITS-1:0] irqMask_r;
	logic [node_id_pkg::IRQ_BITS-1:0] irqMask_nxt;
	logic [31:0] rdata_nxt;
	logic romHostValid_nxt;
	logic [31:0] romHostAddr_nxt;
	logic irq_nxt;
	logic lockedPrev_r;
	logic eventLocked;

	uid_load_if upIf();
	uid_load_if loIf();

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	assign busRstIn = nrst & pcieRstN & global_reset_pin_n & porN;
	assign coldRstIn = nrst & global_reset_pin_n & porN;

	rst_sync syncMain (.clk(ref_clk), .rstInN(nrst), .rstOutN(rstN));
	rst_sync syncBus (.clk(ref_clk), .rstInN(busRstIn), .rstOutN(busRstN));
	rst_sync syncCold (.clk(ref_clk), .rstInN(coldRstIn), .rstOutN(coldRstN));

	// Firmware path is shut off while an EEPROM is fitted
	assign upIf.eepromLoad = eepromValid && eepromUpper; // RL3
	assign upIf.fwWrite = !eepromPresent && regWr && hit(regAddr, node_id_pkg::OFS_UID_UPPER); // RL4
	assign upIf.data = eepromValid ? eepromData : regWdata;
	assign loIf.eepromLoad = eepromValid && !eepromUpper; // RL7
	assign loIf.fwWrite = !eepromPresent && regWr && hit(regAddr, node_id_pkg::OFS_UID_LOWER); // RL7
	assign loIf.data = eepromValid ? eepromData : regWdata;

	uid_quadlet upperQ (.clk(ref_clk), .rstBus(busRstN), .rstCold(coldRstN), .ld(upIf)); // RL1
	uid_quadlet lowerQ (.clk(ref_clk), .rstBus(busRstN), .rstCold(coldRstN), .ld(loIf)); // RL7

	assign eventLocked = upIf.locked && loIf.locked && !lockedPrev_r;

	always_comb begin
		romBase_nxt = romBase_r;
		if (regWr && hit(regAddr, node_id_pkg::OFS_ROM_BASE)) begin
			romBase_nxt = regWdata & node_id_pkg::ROM_BASE_MASK; // RL9
		end
		failLow_nxt = failLow_r;
		failHigh_nxt = failHigh_r;
		if (postFail) begin
			failLow_nxt = postFailOffset[31:0]; // RL10
			failHigh_nxt = {postFailSource, postFailOffset[47:32]}; // RL11 RL12
		end
		irqMask_nxt = irqMask_r;
		if (regWr && hit(regAddr, node_id_pkg::OFS_IRQ_MASK)) begin
			irqMask_nxt = regWdata[node_id_pkg::IRQ_BITS-1:0];
		end
		irqStat_nxt = irqStat_r;
		if (regWr && hit(regAddr, node_id_pkg::OFS_IRQ_STATUS)) begin
			irqStat_nxt = irqStat_r & ~regWdata[node_id_pkg::IRQ_BITS-1:0];
		end
		// Set after clear so a same-cycle event is never lost
		if (postFail) begin
			irqStat_nxt[node_id_pkg::IRQ_FAIL] = 1'b1;
		end
		if (eventLocked) begin
			irqStat_nxt[node_id_pkg::IRQ_LOCKED] = 1'b1;
		end
		irq_nxt = |(irqStat_nxt & irqMask_nxt);
		romHostValid_nxt = romReadReq && (romReadOffset >= node_id_pkg::ROM_WIN_LO)
			&& (romReadOffset <= node_id_pkg::ROM_WIN_HI);
		romHostAddr_nxt = romBase_r
			+ {22'h0, romReadOffset[node_id_pkg::ROM_OFS_BITS-1:0]}; // RL8
		rdata_nxt = 32'h0;
		if (regRd) begin
			case (regAddr)
				node_id_pkg::OFS_UID_UPPER: rdata_nxt = upIf.value;
				node_id_pkg::OFS_UID_LOWER: rdata_nxt = loIf.value;
				node_id_pkg::OFS_ROM_BASE: rdata_nxt = romBase_r; // RL9
				node_id_pkg::OFS_FAIL_LOW: rdata_nxt = failLow_r; // RL13
				node_id_pkg::OFS_FAIL_HIGH: rdata_nxt = failHigh_r; // RL13
				node_id_pkg::OFS_UID_CTRL: rdata_nxt = {30'h0, loIf.locked, upIf.locked};
				node_id_pkg::OFS_IRQ_STATUS: rdata_nxt = {30'h0, irqStat_r};
				node_id_pkg::OFS_IRQ_MASK: rdata_nxt = {30'h0, irqMask_r};
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge busRstN) begin
		if (!busRstN) begin
			romBase_r <= node_id_pkg::ROM_BASE_RESET; // RL9
		end else begin
			romBase_r <= romBase_nxt;
		end
	end

	// Capture registers have no reset; their content is meaningless until a failure
	always_ff @(posedge ref_clk) begin
		failLow_r <= failLow_nxt; // RL13
		failHigh_r <= failHigh_nxt;
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			irqStat_r <= '0;
			irqMask_r <= '0;
			irq <= 1'b0;
			regRdata <= 32'h0;
			romHostValid <= 1'b0;
			romHostAddr <= 32'h0;
			lockedPrev_r <= 1'b0;
		end else begin
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			irq <= irq_nxt;
			regRdata <= rdata_nxt;
			romHostValid <= romHostValid_nxt;
			romHostAddr <= romHostAddr_nxt;
			lockedPrev_r <= upIf.locked && loIf.locked;
		end
	end
endmodule : node_id_rom_map_error_addr_regs

// >>> rtl/rst_sync.sv
`timescale 1ns/10ps
module rst_sync (
	input wire logic clk,
	input wire logic rstInN,
	output logic rstOutN
);
	logic s1_r;
	logic s2_r;
	always_ff @(posedge clk or negedge rstInN) begin
		if (!rstInN) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= 1'b1;
			s2_r <= s1_r;
		end
	end
	assign rstOutN = s2_r;
endmodule : rst_sync

// >>> rtl/uid_quadlet.sv
`timescale 1ns/10ps
module uid_quadlet (
	input wire logic clk,
	input wire logic rstBus,
	input wire logic rstCold,
	uid_load_if.owner ld
);
	logic [31:0] hi_r;
	logic [31:0] hi_nxt;
	logic [node_id_pkg::STICKY_LSB-1:0] lo_r;
	logic [node_id_pkg::STICKY_LSB-1:0] lo_nxt;
	node_id_pkg::load_state_t st_r;
	node_id_pkg::load_state_t st_nxt;
	logic take;

	always_comb begin
		take = (st_r == node_id_pkg::LOAD_OPEN) && (ld.eepromLoad || ld.fwWrite);
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		st_nxt = st_r;
		case (st_r)
			node_id_pkg::LOAD_OPEN: begin
				if (take) begin
					hi_nxt = ld.data;
					lo_nxt = ld.data[node_id_pkg::STICKY_LSB-1:0];
					st_nxt = node_id_pkg::LOAD_LOCKED; // RL3 RL4
				end
			end
			node_id_pkg::LOAD_LOCKED: st_nxt = node_id_pkg::LOAD_LOCKED; // RL4
			default: st_nxt = node_id_pkg::LOAD_OPEN;
		endcase
	end

	// Upper bits and the lock follow any reset; low nibble only the cold ones
	always_ff @(posedge clk or negedge rstBus) begin
		if (!rstBus) begin
			hi_r <= node_id_pkg::UID_RESET; // RL2 RL5
			st_r <= node_id_pkg::LOAD_OPEN;
		end else begin
			hi_r <= hi_nxt;
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstCold) begin
		if (!rstCold) begin
			lo_r <= node_id_pkg::UID_RESET[node_id_pkg::STICKY_LSB-1:0]; // RL6
		end else begin
			lo_r <= lo_nxt;
		end
	end

	assign ld.value = {hi_r[31:node_id_pkg::STICKY_LSB], lo_r};
	assign ld.locked = (st_r == node_id_pkg::LOAD_LOCKED);
endmodule : uid_quadlet

// >>> shared/node_id_pkg.sv
package node_id_pkg;
	localparam logic [7:0] OFS_UID_UPPER = 8'h24;
	localparam logic [7:0] OFS_UID_LOWER = 8'h28;
	localparam logic [7:0] OFS_ROM_BASE = 8'h34;
	localparam logic [7:0] OFS_FAIL_LOW = 8'h38;
	localparam logic [7:0] OFS_FAIL_HIGH = 8'h3c;
	localparam logic [7:0] OFS_UID_CTRL = 8'h60;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h64;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h68;
	localparam logic [31:0] UID_RESET = 32'h0000_0000;
	localparam logic [31:0] ROM_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] ROM_BASE_MASK = 32'hffff_fc00;
	localparam int ROM_OFS_BITS = 10;
	localparam int STICKY_LSB = 4;
	localparam logic [47:0] ROM_WIN_LO = 48'hffff_f000_0400;
	localparam logic [47:0] ROM_WIN_HI = 48'hffff_f000_07ff;
	localparam int SRC_LSB = 16;
	localparam int IRQ_BITS = 2;
	localparam int IRQ_FAIL = 0;
	localparam int IRQ_LOCKED = 1;
	typedef enum logic [1:0] {
		LOAD_OPEN = 2'b00,
		LOAD_LOCKED = 2'b01
	} load_state_t;
endpackage : node_id_pkg

// >>> shared/uid_load_if.sv
`timescale 1ns/10ps
interface uid_load_if;
	logic eepromLoad;
	logic fwWrite;
	logic [31:0] data;
	logic [31:0] value;
	logic locked;
	modport owner(input eepromLoad, input fwWrite, input data, output value, output locked);
	modport user(output eepromLoad, output fwWrite, output data, input value, input locked);
endinterface : uid_load_if

// >>> tb/eeprom_model.sv
`timescale 1ns/10ps
module eeprom_model (
	input wire logic ref_clk,
	output logic eepromPresent,
	output logic eepromValid,
	output logic eepromUpper,
	output logic [31:0] eepromData
);
	initial begin
		eepromPresent = 0;
		eepromValid = 0;
		eepromUpper = 0;
		eepromData = 32'h0;
	end
	task fit(input logic p);
		@(posedge ref_clk) eepromPresent <= p;
	endtask : fit
	// Data inverted when idle so a stale word never looks like a load
	task load(input logic u, input logic [31:0] d);
		@(posedge ref_clk) begin
			eepromValid <= 1;
			eepromUpper <= u;
			eepromData <= d;
		end
		@(posedge ref_clk) begin
			eepromValid <= 0;
			eepromData <= ~d;
		end
	endtask : load
endmodule : eeprom_model

// >>> tb/node_id_checker_properties.sv
`timescale 1ns/10ps
module node_id_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic romReadReq,
	input wire logic [47:0] romReadOffset,
	input wire logic romHostValid,
	input wire logic [31:0] romHostAddr,
	input wire logic postFail,
	input wire logic [47:0] postFailOffset,
	input wire logic [15:0] postFailSource
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic hit;
	assign hit = romReadReq && romReadOffset >= node_id_pkg::ROM_WIN_LO
		&& romReadOffset <= node_id_pkg::ROM_WIN_HI;
	property p_hit; hit |=> romHostValid; endproperty
	a_hit: assert property (p_hit) else $error("rom hit lost");
	property p_miss; !hit |=> !romHostValid; endproperty
	a_miss: assert property (p_miss) else $error("rom stray valid");
	property p_addr; romReadReq |=> romHostAddr[9:0] == $past(romReadOffset[9:0]); endproperty
	a_addr: assert property (p_addr) else $error("rom addr");
	property p_idle; !regRd |=> regRdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data stray");
	property p_low; regRd && regAddr == 8'h34 |=> regRdata[9:0] == 10'h0; endproperty
	a_low: assert property (p_low) else $error("rom base low bits");
	property p_unmap; regRd && regAddr == 8'h00 |=> regRdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_flo;
		postFail ##1 !postFail ##1 (regRd && regAddr == 8'h38)
		|=> regRdata == $past(postFailOffset[31:0], 3);
	endproperty
	a_flo: assert property (p_flo) else $error("fail low");
	property p_fhi;
		postFail ##1 !postFail [*3] ##1 (regRd && regAddr == 8'h3c)
		|=> regRdata == {$past(postFailSource, 5), $past(postFailOffset[47:32], 5)};
	endproperty
	a_fhi: assert property (p_fhi) else $error("fail high");
endmodule : node_id_checker
bind node_id_rom_map_error_addr_regs node_id_checker node_id_checker_inst (.*);

// >>> tb/node_id_rom_map_error_addr_regs_tb_top.sv
`timescale 1ns/10ps
module node_id_rom_map_error_addr_regs_tb_top;
	logic ref_clk, nrst, pcieRstN, global_reset_pin_n, regWr, regRd, irq;
	logic porN = 1'b1;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, romHostAddr;
	logic eepromPresent, eepromValid, eepromUpper, romReadReq, romHostValid, postFail;
	logic [31:0] eepromData;
	logic [47:0] romReadOffset, postFailOffset;
	logic [15:0] postFailSource;
	int badCount = 0;
	int numChecks = 0;
	logic [47:0] ofs [4] = '{48'hffff_f000_0400, 48'hffff_f000_07ff,
		48'hffff_f000_03ff, 48'hffff_f000_0800};
	node_id_rom_map_error_addr_regs node_id_rom_map_error_addr_regs_inst (.*);
	eeprom_model eeprom_model_inst (.*);
	task chk(input logic [31:0] s, input logic [31:0] e);
		numChecks++;
		if (s !== e) begin
			badCount++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk) begin regAddr <= a; regWdata <= d; regWr <= 1; end
		@(posedge ref_clk) regWr <= 0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk) begin regAddr <= a; regRd <= 1; end
		@(posedge ref_clk) regRd <= 0;
		#1 chk(regRdata, e);
	endtask : rd
	// Kind 0 system reset, 1 PCIe reset, 2 global pin, 3 power-on
	task rst(input int k);
		@(posedge ref_clk);
		case (k)
			0: nrst <= 0;
			1: pcieRstN <= 0;
			2: global_reset_pin_n <= 0;
			default: porN <= 0;
		endcase
		repeat (3) @(posedge ref_clk);
		nrst <= 1;
		pcieRstN <= 1;
		global_reset_pin_n <= 1;
		porN <= 1;
		repeat (3) @(posedge ref_clk);
	endtask : rst
	initial begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		badCount++;
		summarize();
	end
	initial begin
		nrst = 0; pcieRstN = 1; global_reset_pin_n = 1; regAddr = 0; regWdata = 0;
		regWr = 0; regRd = 0; romReadReq = 0; romReadOffset = 0; postFail = 0;
		postFailOffset = 0; postFailSource = 0;
		rst(0);
		rd(8'h24, 32'h0);
		rd(8'h28, 32'h0);
		rd(8'h34, 32'h0);
		rd(8'h00, 32'h0);
		wr(8'h24, 32'h1234_567a);
		wr(8'h24, 32'h0);
		rd(8'h24, 32'h1234_567a);
		wr(8'h28, 32'h89ab_cdef);
		rd(8'h28, 32'h89ab_cdef);
		rd(8'h60, 32'h3);
		wr(8'h34, 32'hffff_ffff);
		rd(8'h34, 32'hffff_fc00);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) begin romReadReq <= 1; romReadOffset <= ofs[i]; end
			@(posedge ref_clk) romReadReq <= 0;
			#1 chk(romHostValid, i < 2);
			if (i < 2) chk(romHostAddr, 32'hffff_fc00 + {22'h0, ofs[i][9:0]});
		end
		@(posedge ref_clk) begin
			postFail <= 1;
			postFailOffset <= 48'h1357_cafe_f00d;
			postFailSource <= 16'ha5c3;
		end
		@(posedge ref_clk) postFail <= 0;
		rd(8'h38, 32'hcafe_f00d);
		rd(8'h3c, 32'ha5c3_1357);
		wr(8'h3c, 32'h0);
		rd(8'h3c, 32'ha5c3_1357);
		rd(8'h64, 32'h3);
		wr(8'h68, 32'h1);
		rd(8'h68, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq, 1'b1);
		wr(8'h64, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq, 1'b0);
		// Failure and its clear in one cycle: the new event must survive
		@(posedge ref_clk) begin
			postFail <= 1;
			regAddr <= 8'h64;
			regWdata <= 32'h1;
			regWr <= 1;
		end
		@(posedge ref_clk) begin
			postFail <= 0;
			regWr <= 0;
		end
		rd(8'h64, 32'h3);
		chk(irq, 1'b1);
		rst(1);
		rd(8'h24, 32'h0000_000a);
		rd(8'h28, 32'h0000_000f);
		rd(8'h60, 32'h0);
		rst(2);
		rd(8'h24, 32'h0);
		eeprom_model_inst.fit(1);
		wr(8'h24, 32'h0000_0055);
		eeprom_model_inst.load(1, 32'h0bad_cafe);
		eeprom_model_inst.load(1, 32'h1111_2222);
		rd(8'h24, 32'h0bad_cafe);
		rst(3);
		rd(8'h24, 32'h0);
		summarize();
	end
endmodule : node_id_rom_map_error_addr_regs_tb_top
